/* src/ppo_port.sv */
// Eight-pin bidirectional port with peripheral override, sleep clamp and
// crystal-pin takeover of bit 7.
// Assumes overrides come from logic on clk_i and pad inputs are asynchronous.
//
// Contract
// RULE1 - Sleep clamps digital inputs to ground
// RULE2 - Enabled external interrupt pins escape clamp
// RULE3 - Wake with high disabled pin sets flag
// RULE4 - Pull-up override, else dir/latch/disable 010
// RULE5 - Direction override controls output driver
// RULE6 - Value override selects driven pin value
// RULE7 - Toggle override inverts output latch bit
// RULE8 - Input enable override beats sleep state
// RULE9 - Peripherals get unsynchronised post-Schmitt input
// RULE10 - Owning peripheral generates all override signals
// RULE11 - Fixed alternate function map per bit
// RULE12 - Crystal use withdraws bit 7 from I/O
// RULE13 - Async timer oscillator disconnects bit 7
// RULE14 - Clock-pin bit 7 reads back zero
// RULE15 - Bit 7 is pin change source 7
// RULE16 - Reset turns pull-ups off
// RULE17 - Software waits a cycle before readback; the code delays readback of a written value by three cycles
// RULE18 - Direction one output, zero input
// RULE19 - Writing pin sample one toggles latch
// RULE20 - Pins without alternate function ignore overrides
// RULE21 - Toggle override shares software toggle path
`include "ppo_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ppo_port (
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // Register port
    input  wire ppo_pkg::ppo_addr_t reg_addr_i,
    input  wire ppo_pkg::ppo_byte_t reg_wdata_i,
    input  wire logic              reg_we_i,
    input  wire logic              reg_re_i,
    output logic [7:0]             reg_rdata_o,
    // Peripheral override signals, one bit per pin
    input  wire ppo_pkg::ppo_byte_t pull_up_override_en_i,
    input  wire ppo_pkg::ppo_byte_t pull_up_override_val_i,
    input  wire ppo_pkg::ppo_byte_t dir_override_en_i,
    input  wire ppo_pkg::ppo_byte_t dir_override_val_i,
    input  wire ppo_pkg::ppo_byte_t value_override_en_i,
    input  wire ppo_pkg::ppo_byte_t value_override_val_i,
    input  wire ppo_pkg::ppo_byte_t toggle_override_en_i,
    input  wire ppo_pkg::ppo_byte_t input_en_override_en_i,
    input  wire ppo_pkg::ppo_byte_t input_en_override_val_i,
    // Sleep controller and external interrupt configuration
    input  wire logic              sleep_clamp_i,
    input  wire ppo_pkg::ppo_byte_t ext_int_en_i,
    input  wire ppo_pkg::ppo_byte_t ext_int_edge_cfg_i,
    output logic [7:0]             ext_int_flag_set_o,
    // Pads
    input  wire ppo_pkg::ppo_byte_t pad_i,
    output logic [7:0]             pad_o,
    output logic [7:0]             pad_oe_o,
    output logic [7:0]             pad_pullup_o,
    // Alternate function taps
    output logic [7:0]             alt_fn_input_tap_o,
    output logic                   pin_change_src7_o,
    output logic                   timer_osc_out_pin_o,
    output logic                   crystal_out_pin_o
);
    import ppo_pkg::*;

    // Override selection shared by pull-up, driver, value and input enable
    function automatic ppo_byte_t ovr_sel(input ppo_byte_t en,
                                         input ppo_byte_t val,
                                         input ppo_byte_t dflt);
        ovr_sel = (en & val) | (~en & dflt);
    endfunction

    // Register word decode, shared by every register write path
    function automatic logic reg_hit(input logic      strobe,
                                     input ppo_addr_t addr,
                                     input ppo_addr_t ofs);
        reg_hit = strobe && (addr == ofs);
    endfunction

    ppo_byte_t dir_bit_q;
    ppo_byte_t out_latch_bit_q;
    ppo_byte_t ctrl_q;
    ppo_byte_t pin_sync1_q;
    ppo_byte_t pin_sample_bit_q;
    ppo_byte_t rdata_q;
    ppo_byte_t pad_o_q;
    ppo_byte_t pad_oe_q;
    ppo_byte_t pad_pu_q;
    ppo_byte_t wake_pend_q;
    ppo_byte_t flag_set_q;
    ppo_cnt_t  wake_cnt_q;
    logic      sleep_q;

    logic      pullup_global_off;
    logic      timer2_async_sel;
    logic      ext_clock_in_sel;
    logic      int_rc_sel;
    logic      crystal_sel;
    logic      b7_takeover;
    logic      timer_osc_route;
    ppo_byte_t clock_pin_mask;
    ppo_byte_t alt_mask;

    ppo_byte_t pull_up_override_en;
    ppo_byte_t dir_override_en;
    ppo_byte_t value_override_en;
    ppo_byte_t toggle_override_en;
    ppo_byte_t input_en_override_en;
    ppo_byte_t pull_up_d;
    ppo_byte_t drive_en_d;
    ppo_byte_t drive_val_d;
    ppo_byte_t input_en;
    ppo_byte_t clamped_in;
    ppo_byte_t sw_toggle;
    ppo_byte_t latch_base;
    ppo_byte_t wake_cand;
    logic      wake;

    logic      wr_pin;
    logic      wr_dir;
    logic      wr_out;
    logic      wr_ctrl;

    assign wr_pin  = reg_hit(reg_we_i, reg_addr_i, `PPO_OFS_PIN);
    assign wr_dir  = reg_hit(reg_we_i, reg_addr_i, `PPO_OFS_DIR);
    assign wr_out  = reg_hit(reg_we_i, reg_addr_i, `PPO_OFS_OUT);
    assign wr_ctrl = reg_hit(reg_we_i, reg_addr_i, `PPO_OFS_CTRL);

    assign pullup_global_off = ctrl_q[`PPO_CTRL_PUD];
    assign timer2_async_sel  = ctrl_q[`PPO_CTRL_AS2];
    assign ext_clock_in_sel  = ctrl_q[`PPO_CTRL_EXT_CLOCK_IN_SEL];
    assign int_rc_sel        = ctrl_q[`PPO_CTRL_INTRC];
    assign crystal_sel       = ctrl_q[`PPO_CTRL_XTAL];

    // RULE13 async oscillator route
    assign timer_osc_route = int_rc_sel & timer2_async_sel & ~ext_clock_in_sel;
    // RULE12 crystal pin takeover
    assign b7_takeover = (crystal_sel & ~int_rc_sel) | timer_osc_route;
    assign clock_pin_mask = {b7_takeover, 7'h00};

    // RULE20 mask unused overrides
    assign alt_mask = `PPO_ALT_MASK;

    // RULE10 peripheral-owned overrides
    assign pull_up_override_en  = (pull_up_override_en_i & alt_mask) | clock_pin_mask;
    assign dir_override_en  = (dir_override_en_i & alt_mask) | clock_pin_mask;
    assign value_override_en  = value_override_en_i & alt_mask & ~clock_pin_mask;
    assign toggle_override_en  = toggle_override_en_i & alt_mask & ~clock_pin_mask;
    assign input_en_override_en = (input_en_override_en_i & alt_mask) | clock_pin_mask;

    // RULE4 pull-up decision
    assign pull_up_d = ovr_sel(pull_up_override_en, pull_up_override_val_i & ~clock_pin_mask,
                               ~dir_bit_q & out_latch_bit_q
                               & {8{~pullup_global_off}});

    // RULE5 driver enable
    // RULE18 direction bit sets driver
    assign drive_en_d = ovr_sel(dir_override_en, dir_override_val_i & ~clock_pin_mask,
                                dir_bit_q);

    // RULE6 driven value
    assign drive_val_d = ovr_sel(value_override_en, value_override_val_i, out_latch_bit_q)
                         & drive_en_d;

    // RULE1 sleep clamp
    // RULE2 interrupt pins escape
    // RULE8 input enable override
    assign input_en = ovr_sel(input_en_override_en, input_en_override_val_i & ~clock_pin_mask,
                              {8{~sleep_clamp_i}} | ext_int_en_i);

    // Clamp sits ahead of the Schmitt trigger, so the tap and the
    // synchroniser both see ground while the input is disabled.
    assign clamped_in = pad_i & input_en;

    // RULE9 unsynchronised tap
    assign alt_fn_input_tap_o = clamped_in;
    // RULE15 pin change source
    assign pin_change_src7_o = clamped_in[`PPO_BIT_CRYSTAL_OUT];
    // RULE11 bit 7 oscillator routing
    assign timer_osc_out_pin_o = timer_osc_route;
    assign crystal_out_pin_o   = crystal_sel & ~int_rc_sel;

    // RULE19 software toggle path
    assign sw_toggle  = wr_pin ? reg_wdata_i : 8'h00;
    assign latch_base = wr_out ? reg_wdata_i : out_latch_bit_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dir_bit_q <= `PPO_RST_DIR;
        end else if (wr_dir) begin
            dir_bit_q <= reg_wdata_i & ~clock_pin_mask;
        end
    end

    // RULE16 latch cleared in reset
    // RULE7 toggle override
    // RULE21 same toggle path
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_latch_bit_q <= `PPO_RST_OUT;
        end else begin
            out_latch_bit_q <= (latch_base ^ sw_toggle ^ toggle_override_en) & ~clock_pin_mask;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= `PPO_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata_i & `PPO_CTRL_MASK;
        end
    end

    // Two-stage synchroniser; a written value shows up three cycles later than
    // a write-then-read back to back would expect; the pad register adds one of them.
    // RULE17 readback lags write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_sync1_q <= 8'h00;
        end else begin
            pin_sync1_q <= clamped_in;
        end
    end

    // Only this stage may read the first flop
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_sample_bit_q <= 8'h00;
        end else begin
            pin_sample_bit_q <= pin_sync1_q;
        end
    end

    // RULE14 clock pin reads zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 8'h00;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                `PPO_OFS_PIN: begin
                    rdata_q <= pin_sample_bit_q & ~clock_pin_mask;
                end
                `PPO_OFS_DIR: begin
                    rdata_q <= dir_bit_q & ~clock_pin_mask;
                end
                `PPO_OFS_OUT: begin
                    rdata_q <= out_latch_bit_q & ~clock_pin_mask;
                end
                `PPO_OFS_CTRL: begin
                    rdata_q <= ctrl_q;
                end
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Pad controls are registered so reset forces tri-state with no
    // pull-up, at the cost of one cycle of latency on overrides.
    // RULE16 pull-up off in reset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pad_pu_q <= 8'h00;
        end else begin
            pad_pu_q <= pull_up_d & ~drive_en_d;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pad_o_q <= 8'h00;
        end else begin
            pad_o_q <= drive_val_d;
        end
    end

    // Tri-state in reset, even with no clock running
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pad_oe_q <= 8'h00;
        end else begin
            pad_oe_q <= drive_en_d;
        end
    end

    // Wake from a clamping sleep: the clamp release is itself an edge, so a
    // high pin whose interrupt is off but edge-armed raises its flag once
    // the synchroniser has caught up.
    // RULE3 wake flag
    assign wake      = sleep_q & ~sleep_clamp_i;
    assign wake_cand = ~ext_int_en_i & ext_int_edge_cfg_i;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleep_clamp_i;
        end
    end

    // Candidates are frozen at the wake edge and held until the count ends
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wake_pend_q <= 8'h00;
        end else if (wake) begin
            wake_pend_q <= wake_cand;
        end else if (wake_cnt_q == 2'h0) begin
            wake_pend_q <= 8'h00;
        end
    end

    // Lets the synchroniser catch up with the released clamp
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wake_cnt_q <= 2'h0;
        end else if (wake) begin
            wake_cnt_q <= `PPO_SYNC_STAGES;
        end else if (wake_cnt_q != 2'h0) begin
            wake_cnt_q <= wake_cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flag_set_q <= 8'h00;
        end else if (wake_cnt_q == 2'h1) begin
            flag_set_q <= wake_pend_q & pin_sample_bit_q;
        end else begin
            flag_set_q <= 8'h00;
        end
    end

    assign reg_rdata_o        = rdata_q;
    assign pad_o              = pad_o_q;
    assign pad_oe_o           = pad_oe_q;
    assign pad_pullup_o       = pad_pu_q;
    assign ext_int_flag_set_o = flag_set_q;

endmodule

`default_nettype wire

/* src/ppo_consts.svh */
// Constants for the port pin override logic: register offsets, control bit
// positions, reset values and synchroniser timing.
// Assumes inclusion by bare name from the design file; the package does not include it.
`ifndef PPO_CONSTS_SVH
`define PPO_CONSTS_SVH

// Register word offsets on the plain register port
`define PPO_OFS_PIN       2'h0
`define PPO_OFS_DIR       2'h1
`define PPO_OFS_OUT       2'h2
`define PPO_OFS_CTRL      2'h3

// Bit positions in the control register
`define PPO_CTRL_PUD      0
`define PPO_CTRL_AS2      1
`define PPO_CTRL_EXT_CLOCK_IN_SEL    2
`define PPO_CTRL_INTRC    3
`define PPO_CTRL_XTAL     4
`define PPO_CTRL_MASK     8'h1f

// Reset values
`define PPO_RST_DIR       8'h00
`define PPO_RST_OUT       8'h00
`define PPO_RST_CTRL      8'h08

// Pins that carry an alternate function; all eight do on this port
`define PPO_ALT_MASK      8'hff

// Bit map of the alternate functions
`define PPO_BIT_CRYSTAL_OUT   7
`define PPO_BIT_CRYSTAL_IN    6
`define PPO_BIT_SPI_SCK       5
`define PPO_BIT_SPI_MISO      4
`define PPO_BIT_SPI_MOSI      3
`define PPO_BIT_SPI_SS        2
`define PPO_BIT_T1_CMP_A      1
`define PPO_BIT_T1_CAPTURE    0

// Synchroniser depth seen by the wake check, in clock cycles
`define PPO_SYNC_STAGES   2'h2

`endif

/* src/ppo_pkg.sv */
// Types shared by the port pin override logic.
// Assumes the constants header is on the include path.
package ppo_pkg;
    typedef logic [7:0] ppo_byte_t;
    typedef logic [1:0] ppo_addr_t;
    typedef logic [1:0] ppo_cnt_t;
endpackage

/* dv/ppo_port_assertions.sv */
// Concurrent checks on the ports of the port pin override logic.
// Assumes it is bound to ppo_port and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ppo_port_checker (
    input wire logic               clk_i,
    input wire logic               arst_n_i,
    input wire ppo_pkg::ppo_byte_t pull_up_override_en_i,
    input wire ppo_pkg::ppo_byte_t pull_up_override_val_i,
    input wire ppo_pkg::ppo_byte_t dir_override_en_i,
    input wire ppo_pkg::ppo_byte_t dir_override_val_i,
    input wire ppo_pkg::ppo_byte_t input_en_override_en_i,
    input wire ppo_pkg::ppo_byte_t input_en_override_val_i,
    input wire logic               sleep_clamp_i,
    input wire ppo_pkg::ppo_byte_t ext_int_en_i,
    input wire ppo_pkg::ppo_byte_t pad_i,
    input wire logic [7:0]         pad_o,
    input wire logic [7:0]         pad_oe_o,
    input wire logic [7:0]         pad_pullup_o,
    input wire logic [7:0]         alt_fn_input_tap_o,
    input wire logic               pin_change_src7_o,
    input wire logic               timer_osc_out_pin_o,
    input wire logic               crystal_out_pin_o
);
    import ppo_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Bit 7 is masked where a clock pin may own it
    pull_drive_excl_a: assert property ((pad_pullup_o & pad_oe_o) == 8'h00)
        else $error("pull-up on while driving");
    idle_pad_low_a: assert property ((pad_o & ~pad_oe_o) == 8'h00)
        else $error("pad value without driver");
    dir_override_a: assert property ($past(arst_n_i) |->
        ((pad_oe_o ^ $past(dir_override_val_i)) & $past(dir_override_en_i) & 8'h7f) == 8'h00)
        else $error("driver ignores direction override");
    pullup_override_a: assert property ($past(arst_n_i) |-> ((pad_pullup_o
        ^ $past(pull_up_override_val_i)) & $past(pull_up_override_en_i) & ~pad_oe_o & 8'h7f) == 8'h00)
        else $error("pull-up ignores override");
    input_override_a: assert property (((alt_fn_input_tap_o
        ^ (pad_i & input_en_override_val_i)) & input_en_override_en_i & 8'h7f) == 8'h00)
        else $error("input tap ignores override");
    sleep_clamp_a: assert property (sleep_clamp_i |->
        (alt_fn_input_tap_o & ~input_en_override_en_i & ~ext_int_en_i) == 8'h00)
        else $error("input not clamped in sleep");
    pin_change7_a: assert property (pin_change_src7_o == alt_fn_input_tap_o[7])
        else $error("pin change source 7 wrong");
    clock_pin_a: assert property (timer_osc_out_pin_o || crystal_out_pin_o |->
        !alt_fn_input_tap_o[7] ##1 (!pad_oe_o[7] && !pad_pullup_o[7]))
        else $error("clock pin still used as port");
    cover property (timer_osc_out_pin_o);
    cover property (sleep_clamp_i ##1 !sleep_clamp_i);
    cover property ((pad_oe_o & dir_override_en_i) != 8'h00);
endmodule
bind ppo_port ppo_port_checker u_chk (.*);
`default_nettype wire

/* dv/ppo_periph_model.sv */
// Peripherals that own the alternate functions of the port pins.
// Assumes the bench changes its controls right after rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module ppo_periph_model (
    input  wire logic              spi_mstr_i,
    input  wire logic              cmp_i,
    input  wire logic              tgl_i,
    input  wire logic              pchg_i,
    output var ppo_pkg::ppo_byte_t pull_up_override_en_o,
    output var ppo_pkg::ppo_byte_t pull_up_override_val_o,
    output var ppo_pkg::ppo_byte_t dir_override_en_o,
    output var ppo_pkg::ppo_byte_t dir_override_val_o,
    output var ppo_pkg::ppo_byte_t value_override_en_o,
    output var ppo_pkg::ppo_byte_t value_override_val_o,
    output var ppo_pkg::ppo_byte_t toggle_override_en_o,
    output var ppo_pkg::ppo_byte_t ieoe_o,
    output var ppo_pkg::ppo_byte_t ieov_o
);
    import ppo_pkg::*;
    // SPI bits 5..3, compare bit 1, pin change bit 6
    always_comb begin
        pull_up_override_en_o = {3'h0, spi_mstr_i, 4'h0};
        pull_up_override_val_o = {3'h0, spi_mstr_i, 4'h0};
        dir_override_en_o = {2'h0, {3{spi_mstr_i}}, 3'h0};
        dir_override_val_o = {2'h0, spi_mstr_i, 1'h0, spi_mstr_i, 3'h0};
        value_override_en_o = {2'h0, spi_mstr_i, 1'h0, spi_mstr_i, 1'h0, spi_mstr_i, 1'h0};
        value_override_val_o = {2'h0, cmp_i, 1'h0, ~cmp_i, 1'h0, cmp_i, 1'h0};
        toggle_override_en_o = {6'h0, tgl_i, 1'h0};
        ieoe_o = {1'h0, pchg_i, 6'h0};
        ieov_o = {1'h0, pchg_i, 6'h0};
    end
endmodule
`default_nettype wire

/* dv/tb_port_pin_override_logic.sv */
// Self-checking bench for the port pin override logic.
// Assumes the peripheral model drives all overrides; pads resolve here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_port_pin_override_logic;
    import ppo_pkg::*;
    logic clk_i, arst_n_i, reg_we_i, reg_re_i, sleep_clamp_i, spi_q, cmp_q, tgl_q, pchg_q;
    logic pin_change_src7_o, timer_osc_out_pin_o, crystal_out_pin_o;
    ppo_addr_t reg_addr_i;
    ppo_byte_t reg_wdata_i, ext_int_en_i, ext_int_edge_cfg_i, ext_q, pad_i, seen;
    ppo_byte_t pull_up_override_en_i, pull_up_override_val_i, dir_override_en_i;
    ppo_byte_t dir_override_val_i, value_override_en_i, value_override_val_i;
    ppo_byte_t toggle_override_en_i, input_en_override_en_i, input_en_override_val_i;
    logic [7:0] reg_rdata_o, ext_int_flag_set_o, pad_o, pad_oe_o, pad_pullup_o;
    logic [7:0] alt_fn_input_tap_o;
    int fail_count, comparisons, cycles;
    // Undriven pins follow the outside level, so read-back sees both directions
    assign pad_i = (pad_oe_o & pad_o) | (~pad_oe_o & ext_q);
    ppo_port dut (.*);
    ppo_periph_model peri (.spi_mstr_i(spi_q), .cmp_i(cmp_q), .tgl_i(tgl_q), .pchg_i(pchg_q),
        .pull_up_override_en_o(pull_up_override_en_i), .pull_up_override_val_o(pull_up_override_val_i),
        .dir_override_en_o(dir_override_en_i), .dir_override_val_o(dir_override_val_i),
        .value_override_en_o(value_override_en_i), .value_override_val_o(value_override_val_i),
        .toggle_override_en_o(toggle_override_en_i), .ieoe_o(input_en_override_en_i),
        .ieov_o(input_en_override_val_i));
    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input ppo_addr_t a, input ppo_byte_t d);
        @(posedge clk_i);
        reg_we_i <= 1'h1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'h0;
    endtask
    task automatic rd(input ppo_addr_t a, input ppo_byte_t e);
        @(posedge clk_i);
        reg_re_i <= 1'h1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'h0;
        @(negedge clk_i);
        `CHK("rdata", e, reg_rdata_o)
    endtask
    // Registers land one edge after the write, pads one edge later
    task automatic settle();
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    initial begin
        {reg_we_i, reg_re_i, sleep_clamp_i, spi_q, cmp_q, tgl_q, pchg_q} = '0;
        {reg_addr_i, reg_wdata_i, ext_int_en_i, ext_int_edge_cfg_i, ext_q} = '0;
        arst_n_i = 1'h0;
        repeat (5) @(posedge clk_i);
        `CHK("pullup", 8'h00, pad_pullup_o)
        arst_n_i <= 1'h1;
        rd(2'h3, 8'h08);
        wr(2'h1, 8'h0f);
        wr(2'h2, 8'hc3);
        settle();
        `CHK("oe", 8'h0f, pad_oe_o)
        `CHK("pad", 8'h03, pad_o)
        `CHK("pullup", 8'hc0, pad_pullup_o)
        wr(2'h0, 8'h81);
        rd(2'h2, 8'h42);
        @(posedge clk_i);
        tgl_q <= 1'h1;
        @(posedge clk_i);
        tgl_q <= 1'h0;
        rd(2'h2, 8'h40);
        wr(2'h3, 8'h09);
        ext_q <= 8'h5a;
        settle();
        `CHK("pullup", 8'h00, pad_pullup_o)
        rd(2'h0, 8'h50);
        @(posedge clk_i);
        {spi_q, cmp_q} <= 2'h3;
        settle();
        `CHK("oe", 8'h2f, pad_oe_o)
        `CHK("pad", 8'h22, pad_o)
        `CHK("pullup", 8'h10, pad_pullup_o)
        @(posedge clk_i);
        {spi_q, pchg_q, sleep_clamp_i} <= 3'h3;
        ext_int_en_i <= 8'h10;
        ext_int_edge_cfg_i <= 8'h50;
        settle();
        `CHK("tap", 8'h50, alt_fn_input_tap_o)
        @(posedge clk_i);
        sleep_clamp_i <= 1'h0;
        seen = 8'h00;
        repeat (8) begin
            @(negedge clk_i);
            seen |= ext_int_flag_set_o;
        end
        `CHK("flag", 8'h40, seen)
        @(posedge clk_i);
        ext_q <= 8'hda;
        wr(2'h1, 8'h8f);
        wr(2'h3, 8'h0a);
        settle();
        `CHK("tosc", 1'h1, timer_osc_out_pin_o)
        `CHK("oe", 8'h0f, pad_oe_o)
        rd(2'h1, 8'h0f);
        wr(2'h2, 8'hc0);
        rd(2'h2, 8'h40);
        rd(2'h0, 8'h50);
        wr(2'h3, 8'h10);
        settle();
        `CHK("xtal", 1'h1, crystal_out_pin_o)
        wr(2'h3, 8'h08);
        wr(2'h1, 8'h00);
        wr(2'h2, 8'hc0);
        settle();
        `CHK("pullup", 8'hc0, pad_pullup_o)
        @(posedge clk_i);
        arst_n_i <= 1'h0;
        #1;
        `CHK("pullup", 8'h00, pad_pullup_o)
        tally_and_finish();
    end
endmodule
`default_nettype wire
